// ===== verilog/alu_shift_defs.svh
// Offsets, field positions, reset values and response codes for the ALU/shifter datapath.
// Assumes inclusion by bare name from package and modules alike.
`ifndef ALU_SHIFT_DEFS_SVH
`define ALU_SHIFT_DEFS_SVH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define REG_CTRL_OFS 4'h0
`define REG_STAT_OFS 4'h4
`define CTRL_RST 6'h00
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_MODE16 0
`define CTRL_DECIMAL 1
`define CTRL_LEFT 2
`define CTRL_RIGHT 3
`define CTRL_COPY_ALU 4
`define CTRL_COPY_SH 5
// ----------------------------------------
// Condition vector fields
// ----------------------------------------
`define COND_CARRY 0
`define COND_SIGN 1
`define COND_RESULT 2
`define COND_OVF 3
`define COND_SHB 4
`define COND_SLB 5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== verilog/alu_shift_pkg.sv
// Types shared by the ALU, shifter and carry datapath.
// Assumes nothing beyond the defs header.
`include "alu_shift_defs.svh"
package alu_shift_pkg;
    typedef enum logic [1:0] {
        ALU_LOGIC = 2'h0, ALU_ADD = 2'h1, ALU_SUB = 2'h2, ALU_PASS_LEFT = 2'h3
    } alu_op_e;
    typedef enum logic [3:0] {
        SH_NONE = 4'h0, S_LSL = 4'h1, S_LSR = 4'h2, S_ASR = 4'h3, S_ROL = 4'h4,
        S_ROR = 4'h5, D_LSL = 4'h6, D_LSR = 4'h7, D_ASR = 4'h8, D_ASL = 4'h9,
        D_ROL = 4'hA, D_ROR = 4'hB
    } shift_op_e;
    typedef enum logic [2:0] {
        CY_NONE = 3'h0, SET_CARRY_IN = 3'h1, CLEAR_CARRY_IN = 3'h2,
        SET_CARRY_OUT = 3'h3, CLEAR_CARRY_OUT = 3'h4,
        ADDER_CARRY_TO_OUT_HOLD = 3'h5, ADDER_CARRY_TO_BOTH_HOLDS = 3'h6,
        SHIFT_BIT_TO_OUT_HOLD = 3'h7
    } carry_op_e;
endpackage

// ===== verilog/alu_core.sv
// 18-bit arithmetic-logic unit: sixteen Boolean functions, add, subtract, pass-left.
// Assumes operands are already sign-extended by the caller where needed.
`timescale 1ns/1ps
module alu_core import alu_shift_pkg::*; (
    input wire logic [17:0] a,
    input wire logic [17:0] b,
    input wire logic cin,
    input wire alu_op_e op,
    input wire logic [3:0] func,
    input wire logic mode16,
    output logic [17:0] res,
    output logic cout,
    output logic ovf,
    output logic [3:0] grp_carry
);
    logic [17:0] bb;
    logic [18:0] sum;
    logic [17:0] cy;

    always_comb begin
        bb = (op == ALU_SUB) ? ~b : b;
        sum = {1'b0, a} + {1'b0, bb} + {18'h00000, cin};
        cy = a ^ bb ^ sum[17:0];
        grp_carry = {cy[16], cy[12], cy[8], cy[4]};
        res = sum[17:0];
        cout = mode16 ? cy[16] : sum[18];
        ovf = mode16 ? (cy[16] ^ cy[15]) : (sum[18] ^ cy[17]);
        case (op)
            ALU_LOGIC: begin
                for (int i = 0; i < 18; i++) begin
                    res[i] = func[{a[i], b[i]}];
                end
                cout = 1'b0;
                ovf = 1'b0;
            end
            ALU_PASS_LEFT: begin
                res = a;
                cout = 1'b0;
                ovf = 1'b0;
            end
            default: ;
        endcase
    end
endmodule

// ===== verilog/shift_unit.sv
// Single 18-bit and double 36/37-bit barrel shifter with shift overflow detection.
// Assumes hi_in is the ALU result, lo_in the shifter input, end_in the carry-out hold.
`timescale 1ns/1ps
module shift_unit import alu_shift_pkg::*; (
    input wire logic [17:0] hi_in,
    input wire logic [17:0] lo_in,
    input wire logic end_in,
    input wire shift_op_e op,
    input wire logic [5:0] cnt,
    output logic [17:0] hi_out,
    output logic [17:0] lo_out,
    output logic end_out,
    output logic ovf
);
    logic [5:0] sc, dc, sr, dr;
    logic [35:0] w, t36;
    logic [36:0] t37;
    logic [71:0] t72;

    assign w = {hi_in, lo_in};
    assign sc = (cnt > 6'h12) ? 6'h12 : cnt;
    assign dc = (cnt > 6'h25) ? 6'h25 : cnt;
    assign sr = (sc == 6'h12) ? 6'h00 : sc;
    assign dr = (dc >= 6'h24) ? dc - 6'h24 : dc;

    always_comb begin
        hi_out = hi_in;
        lo_out = lo_in;
        end_out = end_in;
        ovf = 1'b0;
        t36 = 36'h000000000;
        t37 = {end_in, w};
        t72 = {w, w};
        case (op)
            S_LSL: lo_out = lo_in << sc;
            S_LSR: lo_out = lo_in >> sc;
            S_ASR: lo_out = $unsigned($signed(lo_in) >>> sc);
            S_ROL: begin
                t36 = {lo_in, lo_in} << sr;
                lo_out = t36[35:18];
            end
            S_ROR: begin
                t36 = {lo_in, lo_in} >> sr;
                lo_out = t36[17:0];
            end
            D_LSL, D_ASL: begin
                t37 = {end_in, w} << dc;
                {end_out, hi_out, lo_out} = t37;
                for (int i = 1; i < 36; i++) begin
                    if (op == D_ASL && i <= int'(dc) && w[35 - i] != w[35]) ovf = 1'b1;
                end
                // Zero fill reaches the sign position after 36 places
                if (op == D_ASL && dc > 6'h23 && w[35]) ovf = 1'b1;
            end
            D_LSR: begin
                t37 = {end_in, w} >> dc;
                {end_out, hi_out, lo_out} = t37;
            end
            D_ASR: begin
                t36 = $unsigned($signed(w) >>> dc);
                {hi_out, lo_out} = t36;
            end
            D_ROL: begin
                t72 = {w, w} << dr;
                {hi_out, lo_out} = t72[71:36];
            end
            D_ROR: begin
                t72 = {w, w} >> dr;
                {hi_out, lo_out} = t72[35:0];
            end
            default: ;
        endcase
    end
endmodule

// ===== verilog/alu_shifter_carry_datapath.sv
// ALU, shifter, carry holds and condition bits, with an AXI4-Lite control/status slave.
// Assumes step primitives arrive on aclk from the nanoprogram sequencer, one step a cycle.
//
// Functional notes
// - ALU does all sixteen Boolean functions plus add and subtract on 18 bits.
// - ALU result passes shifter extension to ADD bus; gate-ALU loads it.
// - Sixteen-bit mode copies bit 15 into both top bits of ALU inputs.
// - Pass-left routes left operand around adder and skips sign extension.
// - Decimal mode emits 0000 or 0110 per nibble by group carry, top bits zero.
// - No shift copies shifter input to output; gate-shift loads it.
// - Single shifts: logical, arithmetic right, rotates, zero to eighteen places.
// - Single shifts leave the ALU result unchanged on the ADD bus.
// - Double shifts treat ALU result and shifter value as one 36-bit word.
// - Double logical and left arithmetic use 37 bits with end bit; counts to 37.
// - Double left arithmetic equals left logical but may raise overflow.
// - Carry-in hold feeds adder only; loads by set, clear or load-both.
// - Carry-out hold loads by set, clear, adder carry or right switch.
// - Carry-out hold feeds end bit, left switch and carry condition.
// - Shifter output low bit comes from carry-out hold under left control.
// - Shift-to-carry loads end bit, or shifter input low bit under right control.
// - Sixteen-bit mode without right control makes right switch take ADD bus bit 16.
// - Sign is top ADD bit; result ORs low 17 bits, plus shifter under controls.
// - Overflow is shift overflow or differing carries into sign and out.
// - Shifter high and low conditions follow shifter output top and bottom bits.
// - Gate-ALU copies C S R O globally; gate-shift copies shifter conditions.
// - Sixteen-bit mode narrows sign, result, shifter-high, adder carry and overflow.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "alu_shift_defs.svh"
module alu_shifter_carry_datapath import alu_shift_pkg::*; #(
    parameter int WIDTH = 18,
    parameter int ADDR_W = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic [17:0] alu_left_input_bus,
    input wire logic [17:0] alu_right_input_bus,
    input wire logic [17:0] shifter_input_bus,
    input wire alu_op_e alu_op,
    input wire logic [3:0] alu_func,
    input wire shift_op_e shift_op,
    input wire logic [5:0] shift_count,
    input wire carry_op_e carry_op,
    input wire logic gate_alu,
    input wire logic gate_shift_result,
    output logic [17:0] alu_wr_data_q,
    output logic alu_wr_en_q,
    output logic [17:0] sh_wr_data_q,
    output logic sh_wr_en_q,
    output logic carry_in_hold_q,
    output logic carry_out_hold_q,
    output logic [5:0] local_cond_q,
    output logic [5:0] global_cond_q
);
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (WIDTH != 18) begin : g_bad_width
        $error("datapath supports only 18-bit width");
    end
    if (ADDR_W < 3) begin : g_bad_addr
        $error("address width too small for register map");
    end

    logic [5:0] ctrl_q;
    logic mode16, decimal, left_carry_control, right_carry_control;
    assign mode16 = ctrl_q[`CTRL_MODE16];
    assign decimal = ctrl_q[`CTRL_DECIMAL];
    assign left_carry_control = ctrl_q[`CTRL_LEFT];
    assign right_carry_control = ctrl_q[`CTRL_RIGHT];

    // ----------------------------------------
    // ALU operands and arithmetic
    // ----------------------------------------
    logic [17:0] opa, opb, alu_res;
    logic adder_cout, adder_ovf;
    logic [3:0] grp_carry;

    always_comb begin
        opa = alu_left_input_bus;
        opb = alu_right_input_bus;
        if (mode16 && alu_op != ALU_PASS_LEFT) begin
            opa = {{2{alu_left_input_bus[15]}}, alu_left_input_bus[15:0]};
            opb = {{2{alu_right_input_bus[15]}}, alu_right_input_bus[15:0]};
        end
    end

    alu_core u_alu (
        .a(opa),
        .b(opb),
        .cin(carry_in_hold_q),
        .op(alu_op),
        .func(alu_func),
        .mode16(mode16),
        .res(alu_res),
        .cout(adder_cout),
        .ovf(adder_ovf),
        .grp_carry(grp_carry)
    );

    // ----------------------------------------
    // Shifter and shifter extension
    // ----------------------------------------
    logic [17:0] sh_hi, sh_lo, alu_out_high_bus, shifter_output_bus, shifter_out_bus_alt;
    logic shift_end_bit, shift_ovf;

    shift_unit u_shift (
        .hi_in(alu_res),
        .lo_in(shifter_input_bus),
        .end_in(carry_out_hold_q),
        .op(shift_op),
        .cnt(shift_count),
        .hi_out(sh_hi),
        .lo_out(sh_lo),
        .end_out(shift_end_bit),
        .ovf(shift_ovf)
    );

    always_comb begin
        if (decimal) begin
            alu_out_high_bus = alu_res;
            shifter_output_bus = 18'h00000;
            for (int g = 0; g < 4; g++) begin
                shifter_output_bus[4*g +: 4] = grp_carry[g] ? 4'h0 : 4'h6;
            end
        end else begin
            alu_out_high_bus = sh_hi;
            shifter_output_bus = sh_lo;
        end
        shifter_out_bus_alt = shifter_output_bus;
        if (left_carry_control) shifter_out_bus_alt[0] = carry_out_hold_q;
    end

    // ----------------------------------------
    // Right control switch and local conditions
    // ----------------------------------------
    logic right_switch;
    logic [5:0] cond;

    always_comb begin
        if (right_carry_control) begin
            right_switch = shifter_input_bus[0];
        end else if (mode16) begin
            right_switch = alu_out_high_bus[16];
        end else begin
            right_switch = shift_end_bit;
        end
    end

    always_comb begin
        cond[`COND_CARRY] = carry_out_hold_q;
        cond[`COND_SIGN] = mode16 ? alu_out_high_bus[15] : alu_out_high_bus[17];
        cond[`COND_RESULT] = mode16 ? |alu_out_high_bus[14:0] : |alu_out_high_bus[16:0];
        if (left_carry_control || right_carry_control) begin
            cond[`COND_RESULT] = cond[`COND_RESULT] | (|shifter_out_bus_alt);
        end
        cond[`COND_OVF] = shift_ovf | adder_ovf;
        cond[`COND_SHB] = mode16 ? shifter_out_bus_alt[15] : shifter_out_bus_alt[17];
        cond[`COND_SLB] = shifter_out_bus_alt[0];
    end

    // ----------------------------------------
    // Carry hold flip-flops
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carry_in_hold_q <= 1'b0;
        end else begin
            case (carry_op)
                SET_CARRY_IN: carry_in_hold_q <= 1'b1;
                CLEAR_CARRY_IN: carry_in_hold_q <= 1'b0;
                ADDER_CARRY_TO_BOTH_HOLDS: carry_in_hold_q <= adder_cout;
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carry_out_hold_q <= 1'b0;
        end else begin
            case (carry_op)
                SET_CARRY_OUT: carry_out_hold_q <= 1'b1;
                CLEAR_CARRY_OUT: carry_out_hold_q <= 1'b0;
                ADDER_CARRY_TO_OUT_HOLD: carry_out_hold_q <= adder_cout;
                ADDER_CARRY_TO_BOTH_HOLDS: carry_out_hold_q <= adder_cout;
                SHIFT_BIT_TO_OUT_HOLD: carry_out_hold_q <= right_switch;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Gated results and condition copies
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alu_wr_data_q <= 18'h00000;
            alu_wr_en_q <= 1'b0;
            sh_wr_data_q <= 18'h00000;
            sh_wr_en_q <= 1'b0;
            local_cond_q <= 6'h00;
        end else begin
            alu_wr_en_q <= gate_alu;
            sh_wr_en_q <= gate_shift_result;
            if (gate_alu) alu_wr_data_q <= alu_out_high_bus;
            if (gate_shift_result) sh_wr_data_q <= shifter_out_bus_alt;
            local_cond_q <= cond;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_cond_q <= 6'h00;
        end else begin
            if (gate_alu && ctrl_q[`CTRL_COPY_ALU]) begin
                global_cond_q[3:0] <= cond[3:0];
            end
            if (gate_shift_result && ctrl_q[`CTRL_COPY_SH]) begin
                global_cond_q[5:4] <= cond[5:4];
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    logic aw_have_q, w_have_q, aw_take, w_take, commit;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign commit = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            waddr_q <= '0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_take) waddr_q <= s_axi_awaddr;
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            aw_have_q <= commit ? 1'b0 : (aw_have_q || aw_take);
            w_have_q <= commit ? 1'b0 : (w_have_q || w_take);
            s_axi_awready <= commit || !(aw_have_q || aw_take);
            s_axi_wready <= commit || !(w_have_q || w_take);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            ctrl_q <= `CTRL_RST;
        end else begin
            if (commit) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                if (waddr_q[ADDR_W-1:2] == (`REG_CTRL_OFS >> 2)) begin
                    if (wstrb_q[0]) ctrl_q <= wdata_q[5:0];
                end else if (waddr_q[ADDR_W-1:2] != (`REG_STAT_OFS >> 2)) begin
                    s_axi_bresp <= `RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                s_axi_rdata <= 32'h00000000;
                if (s_axi_araddr[ADDR_W-1:2] == (`REG_CTRL_OFS >> 2)) begin
                    s_axi_rdata[5:0] <= ctrl_q;
                end else if (s_axi_araddr[ADDR_W-1:2] == (`REG_STAT_OFS >> 2)) begin
                    s_axi_rdata[15:0] <= {2'h0, local_cond_q, global_cond_q,
                        carry_out_hold_q, carry_in_hold_q};
                end else begin
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_cin_src;
        !(carry_op inside {SET_CARRY_IN, CLEAR_CARRY_IN, ADDER_CARRY_TO_BOTH_HOLDS})
            |=> $stable(carry_in_hold_q);
    endproperty
    a_cin_src: assert property (p_cin_src) else $error("carry-in hold changed");

    property p_both;
        carry_op == ADDER_CARRY_TO_BOTH_HOLDS
            |=> carry_in_hold_q == $past(adder_cout) && carry_out_hold_q == $past(adder_cout);
    endproperty
    a_both: assert property (p_both) else $error("load-both mismatch");

    property p_sh_to_cout;
        carry_op == SHIFT_BIT_TO_OUT_HOLD && right_carry_control
            |=> carry_out_hold_q == $past(shifter_input_bus[0]);
    endproperty
    a_sh_to_cout: assert property (p_sh_to_cout) else $error("right switch wrong");

    property p_gate_alu;
        gate_alu |=> alu_wr_en_q && alu_wr_data_q == $past(alu_out_high_bus);
    endproperty
    a_gate_alu: assert property (p_gate_alu) else $error("gate-ALU data wrong");

    property p_pass_through;
        shift_op == SH_NONE && !decimal && !left_carry_control
            |-> shifter_out_bus_alt == shifter_input_bus;
    endproperty
    a_pass_through: assert property (p_pass_through) else $error("no-shift copy");

    property p_decimal;
        decimal |-> shifter_output_bus[17:16] == 2'h0
            && shifter_output_bus[3:0] == (grp_carry[0] ? 4'h0 : 4'h6);
    endproperty
    a_decimal: assert property (p_decimal) else $error("decimal word wrong");

    property p_left_switch;
        left_carry_control |-> shifter_out_bus_alt[0] == carry_out_hold_q;
    endproperty
    a_left_switch: assert property (p_left_switch) else $error("left switch wrong");

    property p_copy_alu;
        gate_alu && ctrl_q[`CTRL_COPY_ALU] ##1 !gate_alu
            |-> global_cond_q[3:0] == $past(cond[3:0]) ##1 $stable(global_cond_q[3:0]);
    endproperty
    a_copy_alu: assert property (p_copy_alu) else $error("global copy wrong");

    property p_sign16;
        mode16 |-> cond[`COND_SIGN] == alu_out_high_bus[15];
    endproperty
    a_sign16: assert property (p_sign16) else $error("16-bit sign wrong");

    c_dshift: cover property (shift_op == D_ASL && shift_ovf);
    c_decimal: cover property (decimal && gate_shift_result);
    c_both: cover property (carry_op == ADDER_CARRY_TO_BOTH_HOLDS ##1 gate_alu);
endmodule

// ===== tb/local_store_model.sv
// Local store model: two registers loaded by the gated result buses.
// Assumes one-cycle write enables on aclk.
`timescale 1ns/1ps
module local_store_model (
    input wire logic aclk,
    input wire logic alu_wr_en_q,
    input wire logic [17:0] alu_wr_data_q,
    input wire logic sh_wr_en_q,
    input wire logic [17:0] sh_wr_data_q,
    output logic [17:0] ls_alu_q,
    output logic [17:0] ls_sh_q
);
    always_ff @(posedge aclk) begin
        if (alu_wr_en_q) ls_alu_q <= alu_wr_data_q;
        if (sh_wr_en_q) ls_sh_q <= sh_wr_data_q;
    end
endmodule

// ===== tb/alu_shifter_carry_datapath_tb.sv
// Bench: table of datapath steps, then carry, mode and bus cases.
// Assumes the local store model captures gated results.
`timescale 1ns/1ps
module alu_shifter_carry_datapath_tb import alu_shift_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [17:0] alu_left_input_bus = 18'h0, alu_right_input_bus = 18'h0;
    logic [17:0] shifter_input_bus = 18'h0, alu_wr_data_q, sh_wr_data_q, ls_alu_q, ls_sh_q;
    alu_op_e alu_op = ALU_LOGIC;
    shift_op_e shift_op = SH_NONE;
    carry_op_e carry_op = CY_NONE;
    logic [3:0] alu_func = 4'h0;
    logic [5:0] shift_count = 6'h0, local_cond_q, global_cond_q;
    logic gate_alu = 1'b0, gate_shift_result = 1'b0;
    logic alu_wr_en_q, sh_wr_en_q, carry_in_hold_q, carry_out_hold_q;
    int n_mismatch = 0;
    int cmp_count = 0;
    typedef struct packed {
        alu_op_e op;
        logic [3:0] f;
        shift_op_e so;
        logic [5:0] n;
        logic [17:0] a, b, s, ea, es;
    } row_s;
    row_s rows [5] = '{
        '{ALU_ADD, 4'h0, SH_NONE, 6'h0, 18'h5, 18'h3, 18'h11, 18'h8, 18'h11},
        '{ALU_LOGIC, 4'h8, S_LSL, 6'h1, 18'h3000F, 18'hF0FF, 18'h20001, 18'hF, 18'h2},
        '{ALU_PASS_LEFT, 4'h0, S_ASR, 6'h2, 18'h2AAAA, 18'h0, 18'h20000, 18'h2AAAA, 18'h38000},
        '{ALU_PASS_LEFT, 4'h0, D_LSL, 6'h1, 18'h20000, 18'h0, 18'h20000, 18'h1, 18'h0},
        '{ALU_PASS_LEFT, 4'h0, D_ROR, 6'h1, 18'h1, 18'h0, 18'h0, 18'h0, 18'h20000}
    };
    alu_shifter_carry_datapath i_dut (.*);
    local_store_model i_ls (.*);
    always #10 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input row_s r, input carry_op_e c);
        @(posedge aclk);
        alu_op <= r.op;
        shift_op <= r.so;
        carry_op <= c;
        {alu_func, shift_count, gate_alu, gate_shift_result} <= {r.f, r.n, 2'b11};
        {alu_left_input_bus, alu_right_input_bus, shifter_input_bus} <= {r.a, r.b, r.s};
        @(posedge aclk);
        carry_op <= CY_NONE;
        {gate_alu, gate_shift_result} <= 2'b00;
        @(posedge aclk);
        #1;
    endtask
    task automatic axw(input logic [3:0] ad, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] ad);
        @(posedge aclk);
        s_axi_araddr <= ad;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #(20 * 3000);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk({carry_in_hold_q, carry_out_hold_q, global_cond_q}, 32'h0);
        foreach (rows[i]) begin
            step(rows[i], CY_NONE);
            chk(ls_alu_q, rows[i].ea);
            chk(ls_sh_q, rows[i].es);
        end
        $display("table done");
        axw(4'h0, 32'h10);
        step('{ALU_ADD, 4'h0, SH_NONE, 6'h0, 18'h1FFFF, 18'h1, 18'h0, 18'h0, 18'h0}, CY_NONE);
        chk(local_cond_q[3:1], 32'h5);
        chk(global_cond_q[3:1], 32'h5);
        step('{ALU_ADD, 4'h0, SH_NONE, 6'h0, 18'h3FFFF, 18'h1, 18'h0, 18'h0, 18'h0},
            ADDER_CARRY_TO_BOTH_HOLDS);
        axr(4'h4);
        chk(rd[1:0], 32'h3);
        step('{ALU_SUB, 4'h0, SH_NONE, 6'h0, 18'h5, 18'h3, 18'h0, 18'h0, 18'h0}, CY_NONE);
        chk(ls_alu_q, 32'h2);
        $display("carry done");
        axw(4'h0, 32'h4);
        step('{ALU_ADD, 4'h0, SH_NONE, 6'h0, 18'h0, 18'h0, 18'h2, 18'h0, 18'h0}, CY_NONE);
        chk(ls_sh_q, 32'h3);
        axw(4'h0, 32'h8);
        step('{ALU_ADD, 4'h0, SH_NONE, 6'h0, 18'h0, 18'h0, 18'h2, 18'h0, 18'h0},
            SHIFT_BIT_TO_OUT_HOLD);
        chk(carry_out_hold_q, 32'h0);
        axw(4'h0, 32'h2);
        step('{ALU_ADD, 4'h0, SH_NONE, 6'h0, 18'hF, 18'h1, 18'h3FFFF, 18'h0, 18'h0}, CY_NONE);
        chk(ls_sh_q, 32'h6660);
        axw(4'h0, 32'h1);
        step('{ALU_ADD, 4'h0, SH_NONE, 6'h0, 18'h8000, 18'h0, 18'h0, 18'h0, 18'h0},
            SHIFT_BIT_TO_OUT_HOLD);
        chk(ls_alu_q, 32'h38001);
        chk(carry_out_hold_q, 32'h1);
        step('{ALU_PASS_LEFT, 4'h0, SH_NONE, 6'h0, 18'h8000, 18'h0, 18'h0, 18'h0, 18'h0}, CY_NONE);
        chk(ls_alu_q, 32'h8000);
        axw(4'h0, 32'h20);
        step('{ALU_PASS_LEFT, 4'h0, D_ASL, 6'h1, 18'h10000, 18'h0, 18'h30001, 18'h0, 18'h0},
            CY_NONE);
        chk(ls_alu_q, 32'h20001);
        chk(ls_sh_q, 32'h20002);
        chk(local_cond_q[5:3], 32'h3);
        chk(global_cond_q[5:4], 32'h1);
        step('{ALU_PASS_LEFT, 4'h0, D_LSL, 6'h1, 18'h10000, 18'h0, 18'h30001, 18'h0, 18'h0},
            CY_NONE);
        chk(local_cond_q[3], 32'h0);
        $display("modes done");
        axw(4'h8, 32'h3F);
        chk(rr, 32'h2);
        axr(4'h0);
        chk(rd, 32'h20);
        axr(4'h8);
        chk(rr, 32'h2);
        $display("bus done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk({carry_in_hold_q, carry_out_hold_q, global_cond_q, local_cond_q}, 32'h0);
        axr(4'h0);
        chk(rd, 32'h0);
        $display("reset done");
        wrap_up();
    end
endmodule
